// ==== include/preset_output_consts.vh ====
`ifndef PRESET_OUTPUT_CONSTS_VH
`define PRESET_OUTPUT_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_OUT1_CFG 12'h000
`define OFS_OUT2_CFG 12'h004
`define OFS_SETPT_LO1 12'h008
`define OFS_SETPT_HI1 12'h00C
`define OFS_SETPT_LO2 12'h010
`define OFS_SETPT_HI2 12'h014
`define OFS_PRESET1 12'h018
`define OFS_PRESET2 12'h01C
`define OFS_RESET_CFG 12'h020
`define OFS_STATUS 12'h024
`define OFS_IRQ_STAT 12'h028
`define OFS_IRQ_MASK 12'h02C
`define OFS_DELAY1 12'h030
`define OFS_DELAY2 12'h034

// ----------------------------------------
// Output config fields
// ----------------------------------------
`define MODE_LSB 0
`define SRC_BIT 2
`define BATCH_BIT 3
`define UNTIL_LSB 4

// ----------------------------------------
// Modes
// ----------------------------------------
`define MODE_DISABLED 2'h0
`define MODE_TIMED 2'h1
`define MODE_LATCHED 2'h2
`define MODE_BOUNDARY 2'h3

// ----------------------------------------
// Latch release choices
// ----------------------------------------
`define UNTIL_RESET 3'h0
`define UNTIL_LO1 3'h1
`define UNTIL_LO2 3'h2
`define UNTIL_HI2 3'h3
`define UNTIL_PRESET 3'h4

// ----------------------------------------
// Auto reset choices
// ----------------------------------------
`define AUTO_OFF 3'h0
`define AUTO_LO1 3'h1
`define AUTO_LO2 3'h2
`define AUTO_HI2 3'h3
`define AUTO_OUT1_TO 3'h4
`define AUTO_OUT2_TO 3'h5

// ----------------------------------------
// Reset config fields
// ----------------------------------------
`define AUTO_LSB 0
`define BTN_EN_BIT 3
`define PWRUP_BIT 4

// ----------------------------------------
// Reset values, setpoint limits and delay tick timing
// ----------------------------------------
`define OUT_CFG_RST 8'h02
`define RESET_CFG_RST 8'h08
`define SETPT_LO1_RST 24'h00000A
`define SETPT_HI1_RST 24'h000014
`define SETPT_LO2_RST 24'h00001E
`define SETPT_HI2_RST 24'h000028
`define SETPT_MIN (-24'sd99999)
`define SETPT_MAX 24'sd999999
`define DELAY_RST 16'h03E8
`define DELAY_TICK_NS 10000000
`define CLOCK_NS 10
`define DELAY_TICK_CYCLES (`DELAY_TICK_NS / `CLOCK_NS)

`endif

// ==== hw/delay_timer.v ====
`include "preset_output_consts.vh"
`default_nettype none

module delay_timer #(
  parameter TICK_CYCLES = `DELAY_TICK_CYCLES
) (
  input wire clock,
  input wire reset,
  input wire start,
  input wire [15:0] delay,
  output reg running_reg,
  output reg done_reg
);

reg [31:0] tick_reg;
reg [15:0] left_reg;

// ----------------------------------------
// Hundredths countdown
// ----------------------------------------
always @(posedge clock or posedge reset) begin
  if (reset) begin
    tick_reg <= 32'h00000000;
    left_reg <= 16'h0000;
    running_reg <= 1'b0;
    done_reg <= 1'b0;
  end else begin
    done_reg <= 1'b0;
    if (start) begin
      running_reg <= (delay != 16'h0000);
      done_reg <= (delay == 16'h0000);
      left_reg <= delay;
      tick_reg <= 32'h00000000;
    end else if (running_reg) begin
      if (tick_reg == TICK_CYCLES - 1) begin
        tick_reg <= 32'h00000000;
        left_reg <= left_reg - 16'h0001;
        if (left_reg == 16'h0001) begin
          running_reg <= 1'b0;
          done_reg <= 1'b1;
        end
      end else begin
        tick_reg <= tick_reg + 32'h00000001;
      end
    end
  end
end

endmodule
`default_nettype wire

// ==== hw/setpoint_output.v ====
`include "preset_output_consts.vh"
`default_nettype none

module setpoint_output #(
  parameter TICK_CYCLES = `DELAY_TICK_CYCLES
) (
  input wire clock,
  input wire reset,
  input wire [7:0] cfg,
  input wire [15:0] delay,
  input wire signed [23:0] count_value,
  input wire signed [23:0] low_setpoint,
  input wire signed [23:0] high_setpoint,
  input wire reached_lo1,
  input wire reached_lo2,
  input wire reached_hi2,
  input wire count_reset,
  input wire preset_event,
  output reg active_reg,
  output wire activate,
  output wire timeout
);

wire [1:0] mode = cfg[`MODE_LSB+1:`MODE_LSB];
wire [2:0] until_sel = cfg[`UNTIL_LSB+2:`UNTIL_LSB];
wire at_low = (count_value >= low_setpoint);
wire in_bound = at_low && (count_value <= high_setpoint);
reg at_low_reg;
reg release_hit;
wire running;
wire rise = at_low && !at_low_reg;

assign activate = rise && (mode == `MODE_TIMED || mode == `MODE_LATCHED) && !active_reg;

delay_timer #(
  .TICK_CYCLES(TICK_CYCLES)
) timer (
  .clock(clock),
  .reset(reset),
  .start(activate && mode == `MODE_TIMED),
  .delay(delay),
  .running_reg(running),
  .done_reg(timeout)
);

// ----------------------------------------
// Latch release
// ----------------------------------------
always @* begin
  case (until_sel)
    `UNTIL_LO1: release_hit = reached_lo1;
    `UNTIL_LO2: release_hit = reached_lo2;
    `UNTIL_HI2: release_hit = reached_hi2;
    `UNTIL_PRESET: release_hit = preset_event;
    default: release_hit = count_reset;
  endcase
end

// ----------------------------------------
// Output state
// ----------------------------------------
always @(posedge clock or posedge reset) begin
  if (reset) begin
    active_reg <= 1'b0;
    at_low_reg <= 1'b0;
  end else begin
    at_low_reg <= at_low;
    case (mode)
      `MODE_TIMED: active_reg <= activate || (running && !timeout);
      `MODE_LATCHED: begin
        if (activate) begin
          active_reg <= 1'b1;
        end else if (release_hit) begin
          active_reg <= 1'b0;
        end
      end
      `MODE_BOUNDARY: active_reg <= in_bound;
      default: active_reg <= 1'b0;
    endcase
  end
end

endmodule
`default_nettype wire

// ==== hw/preset_output_reset_control.v ====
// The APB register port and the register addresses were left to the implementer.
`include "preset_output_consts.vh"
`default_nettype none

module preset_output_reset_control #(
  parameter TICK_CYCLES = `DELAY_TICK_CYCLES
) (
  input wire clock,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire signed [23:0] first_count,
  input wire signed [23:0] second_count,
  input wire panel_reset_button,
  output reg first_output_reg,
  output reg second_output_reg,
  output reg first_count_load_reg,
  output reg second_count_load_reg,
  output reg signed [23:0] first_load_value_reg,
  output reg signed [23:0] second_load_value_reg,
  output wire irq
);

// ----------------------------------------
// Configuration registers
// ----------------------------------------
reg [7:0] out1_cfg_reg;
reg [7:0] out2_cfg_reg;
reg [7:0] reset_cfg_reg;
reg signed [23:0] first_low_setpoint_reg;
reg signed [23:0] first_high_setpoint_reg;
reg signed [23:0] second_low_setpoint_reg;
reg signed [23:0] second_high_setpoint_reg;
reg signed [23:0] first_count_preset_reg;
reg signed [23:0] second_count_preset_reg;
reg [15:0] delay1_reg;
reg [15:0] delay2_reg;
reg [3:0] irq_stat_reg;
reg [3:0] irq_mask_reg;
reg pwrup_pending_reg;
reg btn_meta_reg;
reg btn_sync_reg;
reg btn_prev_reg;

wire wr = psel && penable && pwrite;
wire [23:0] wdata24 = pwdata[23:0];
wire signed [23:0] wclamp;
wire [2:0] auto_sel = reset_cfg_reg[`AUTO_LSB+2:`AUTO_LSB];
wire panel_reset_button_enable = reset_cfg_reg[`BTN_EN_BIT];
wire powerup_reset_select = reset_cfg_reg[`PWRUP_BIT];

assign pready = 1'b1;
assign pslverr = 1'b0;

// Clamp written setpoints to legal range
assign wclamp = ($signed(wdata24) < `SETPT_MIN) ? `SETPT_MIN :
                ($signed(wdata24) > `SETPT_MAX) ? `SETPT_MAX : $signed(wdata24);

// ----------------------------------------
// Source select and comparisons
// ----------------------------------------
wire signed [23:0] src1 = out1_cfg_reg[`SRC_BIT] ? second_count : first_count;
wire signed [23:0] second_output_source = out2_cfg_reg[`SRC_BIT] ? second_count : first_count;
reg lo1_prev_reg;
reg lo2_prev_reg;
reg hi2_prev_reg;
wire lo1_at = (src1 >= first_low_setpoint_reg);
wire lo2_at = (second_output_source >= second_low_setpoint_reg);
wire hi2_at = (second_output_source >= second_high_setpoint_reg);
wire reached_lo1 = lo1_at && !lo1_prev_reg;
wire reached_lo2 = lo2_at && !lo2_prev_reg;
wire reached_hi2 = hi2_at && !hi2_prev_reg;

// ----------------------------------------
// Reset events
// ----------------------------------------
wire act1;
wire act2;
wire to1;
wire to2;
wire o1;
wire o2;
reg auto_hit;
wire manual_reset = btn_sync_reg && !btn_prev_reg && panel_reset_button_enable;
wire pwrup_reset = pwrup_pending_reg && powerup_reset_select;
wire count_reset = manual_reset || auto_hit || pwrup_reset;
wire batch1 = act1 && out1_cfg_reg[`BATCH_BIT] && out1_cfg_reg[`SRC_BIT];
wire batch2 = act2 && out2_cfg_reg[`BATCH_BIT];

always @* begin
  case (auto_sel)
    `AUTO_LO1: auto_hit = reached_lo1;
    `AUTO_LO2: auto_hit = reached_lo2;
    `AUTO_HI2: auto_hit = reached_hi2;
    `AUTO_OUT1_TO: auto_hit = to1;
    `AUTO_OUT2_TO: auto_hit = to2;
    default: auto_hit = 1'b0;
  endcase
end

// ----------------------------------------
// Output channels
// ----------------------------------------
setpoint_output #(
  .TICK_CYCLES(TICK_CYCLES)
) out1 (
  .clock(clock),
  .reset(reset),
  .cfg(out1_cfg_reg),
  .delay(delay1_reg),
  .count_value(src1),
  .low_setpoint(first_low_setpoint_reg),
  .high_setpoint(first_high_setpoint_reg),
  .reached_lo1(reached_lo1),
  .reached_lo2(reached_lo2),
  .reached_hi2(reached_hi2),
  .count_reset(count_reset),
  .preset_event(first_count_load_reg),
  .active_reg(o1),
  .activate(act1),
  .timeout(to1)
);

setpoint_output #(
  .TICK_CYCLES(TICK_CYCLES)
) out2 (
  .clock(clock),
  .reset(reset),
  .cfg(out2_cfg_reg),
  .delay(delay2_reg),
  .count_value(second_output_source),
  .low_setpoint(second_low_setpoint_reg),
  .high_setpoint(second_high_setpoint_reg),
  .reached_lo1(reached_lo1),
  .reached_lo2(reached_lo2),
  .reached_hi2(reached_hi2),
  .count_reset(count_reset),
  .preset_event(first_count_load_reg),
  .active_reg(o2),
  .activate(act2),
  .timeout(to2)
);

// ----------------------------------------
// Event flops, loads and sync
// ----------------------------------------
always @(posedge clock or posedge reset) begin
  if (reset) begin
    lo1_prev_reg <= 1'b0;
    lo2_prev_reg <= 1'b0;
    hi2_prev_reg <= 1'b0;
    btn_meta_reg <= 1'b0;
    btn_sync_reg <= 1'b0;
    btn_prev_reg <= 1'b0;
    pwrup_pending_reg <= 1'b1;
    first_count_load_reg <= 1'b0;
    second_count_load_reg <= 1'b0;
    first_load_value_reg <= 24'h000000;
    second_load_value_reg <= 24'h000000;
    first_output_reg <= 1'b0;
    second_output_reg <= 1'b0;
  end else begin
    lo1_prev_reg <= lo1_at;
    lo2_prev_reg <= lo2_at;
    hi2_prev_reg <= hi2_at;
    btn_meta_reg <= panel_reset_button;
    btn_sync_reg <= btn_meta_reg;
    btn_prev_reg <= btn_sync_reg;
    // Pending until fired or software writes the select off
    pwrup_pending_reg <= pwrup_pending_reg && !pwrup_reset &&
                         !(wr && paddr == `OFS_RESET_CFG && !pwdata[`PWRUP_BIT]);
    first_output_reg <= o1;
    second_output_reg <= o2;
    first_count_load_reg <= count_reset;
    second_count_load_reg <= count_reset || batch1 || batch2;
    first_load_value_reg <= first_count_preset_reg;
    second_load_value_reg <= second_count_preset_reg;
  end
end

// ----------------------------------------
// APB writes and interrupt status
// ----------------------------------------
wire [3:0] irq_events = {to2, to1, act2, act1};

always @(posedge clock or posedge reset) begin
  if (reset) begin
    out1_cfg_reg <= `OUT_CFG_RST;
    out2_cfg_reg <= `OUT_CFG_RST;
    reset_cfg_reg <= `RESET_CFG_RST;
    first_low_setpoint_reg <= `SETPT_LO1_RST;
    first_high_setpoint_reg <= `SETPT_HI1_RST;
    second_low_setpoint_reg <= `SETPT_LO2_RST;
    second_high_setpoint_reg <= `SETPT_HI2_RST;
    first_count_preset_reg <= 24'h000000;
    second_count_preset_reg <= 24'h000000;
    delay1_reg <= `DELAY_RST;
    delay2_reg <= `DELAY_RST;
    irq_stat_reg <= 4'h0;
    irq_mask_reg <= 4'h0;
  end else begin
    if (wr) begin
      case (paddr)
        `OFS_OUT1_CFG: out1_cfg_reg <= pwdata[7:0];
        `OFS_OUT2_CFG: out2_cfg_reg <= pwdata[7:0];
        `OFS_SETPT_LO1: first_low_setpoint_reg <= wclamp;
        `OFS_SETPT_HI1: first_high_setpoint_reg <= wclamp;
        `OFS_SETPT_LO2: second_low_setpoint_reg <= wclamp;
        `OFS_SETPT_HI2: second_high_setpoint_reg <= wclamp;
        `OFS_PRESET1: first_count_preset_reg <= wclamp;
        `OFS_PRESET2: second_count_preset_reg <= wclamp;
        `OFS_RESET_CFG: reset_cfg_reg <= pwdata[7:0];
        `OFS_IRQ_MASK: irq_mask_reg <= pwdata[3:0];
        `OFS_DELAY1: delay1_reg <= pwdata[15:0];
        `OFS_DELAY2: delay2_reg <= pwdata[15:0];
        default: ;
      endcase
    end
    if (wr && paddr == `OFS_IRQ_STAT) begin
      irq_stat_reg <= (irq_stat_reg & ~pwdata[3:0]) | irq_events;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_events;
    end
  end
end

assign irq = |(irq_stat_reg & irq_mask_reg);

// ----------------------------------------
// APB read mux
// ----------------------------------------
always @* begin
  case (paddr)
    `OFS_OUT1_CFG: prdata = {24'h000000, out1_cfg_reg};
    `OFS_OUT2_CFG: prdata = {24'h000000, out2_cfg_reg};
    `OFS_SETPT_LO1: prdata = {{8{first_low_setpoint_reg[23]}}, first_low_setpoint_reg};
    `OFS_SETPT_HI1: prdata = {{8{first_high_setpoint_reg[23]}}, first_high_setpoint_reg};
    `OFS_SETPT_LO2: prdata = {{8{second_low_setpoint_reg[23]}}, second_low_setpoint_reg};
    `OFS_SETPT_HI2: prdata = {{8{second_high_setpoint_reg[23]}}, second_high_setpoint_reg};
    `OFS_PRESET1: prdata = {{8{first_count_preset_reg[23]}}, first_count_preset_reg};
    `OFS_PRESET2: prdata = {{8{second_count_preset_reg[23]}}, second_count_preset_reg};
    `OFS_RESET_CFG: prdata = {24'h000000, reset_cfg_reg};
    `OFS_STATUS: prdata = {30'h00000000, second_output_reg, first_output_reg};
    `OFS_IRQ_STAT: prdata = {28'h0000000, irq_stat_reg};
    `OFS_IRQ_MASK: prdata = {28'h0000000, irq_mask_reg};
    `OFS_DELAY1: prdata = {16'h0000, delay1_reg};
    `OFS_DELAY2: prdata = {16'h0000, delay2_reg};
    default: prdata = 32'h00000000;
  endcase
end

endmodule
`default_nettype wire

// ==== testbench/preset_output_reset_control_chk.sv ====
`include "preset_output_consts.vh"
`default_nettype none
module preset_output_reset_control_chk (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic first_output_reg,
  input wire logic second_output_reg,
  input wire logic first_count_load_reg,
  input wire logic second_count_load_reg,
  input wire logic signed [23:0] first_load_value_reg,
  input wire logic signed [23:0] second_load_value_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic acc;
  logic ok_val;
  assign acc = psel && penable;
  assign ok_val = $signed(pwdata) >= -32'sh0001869F && $signed(pwdata) <= 32'sh000F423F;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  chk_zero_wait_ok: assert property (acc |-> pready && !pslverr)
    else $error("apb wait or error seen");
  chk_load1_one_cycle: assert property (first_count_load_reg |=> !first_count_load_reg)
    else $error("first load pulse too long");
  chk_load2_one_cycle: assert property (second_count_load_reg |=> !second_count_load_reg)
    else $error("second load pulse too long");
  chk_loads_paired: assert property (first_count_load_reg |-> second_count_load_reg)
    else $error("first load without second load");
  chk_preset1_range: assert property (first_load_value_reg >= `SETPT_MIN &&
    first_load_value_reg <= `SETPT_MAX) else $error("first preset out of range");
  chk_preset1_write: assert property (acc && pwrite && paddr == `OFS_PRESET1 && ok_val
    |-> ##2 first_load_value_reg == $past(pwdata[23:0], 2)) else $error("first preset not stored");
  chk_preset2_write: assert property (acc && pwrite && paddr == `OFS_PRESET2 && ok_val
    |-> ##2 second_load_value_reg == $past(pwdata[23:0], 2))
    else $error("second preset not stored");
  chk_status_read: assert property (acc && !pwrite && paddr == `OFS_STATUS
    |-> prdata[1:0] == {second_output_reg, first_output_reg}) else $error("status mismatch");
  chk_unmapped_zero: assert property (acc && !pwrite && paddr > 12'h034 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind preset_output_reset_control preset_output_reset_control_chk
  preset_output_reset_control_chk_inst (.clock, .reset, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .first_output_reg, .second_output_reg,
  .first_count_load_reg, .second_count_load_reg, .first_load_value_reg,
  .second_load_value_reg);
`default_nettype wire

// ==== testbench/count_source_model.sv ====
`default_nettype none
module count_source_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic set_en,
  input wire logic signed [23:0] set_first,
  input wire logic signed [23:0] set_second,
  input wire logic first_count_load_reg,
  input wire logic second_count_load_reg,
  input wire logic signed [23:0] first_load_value_reg,
  input wire logic signed [23:0] second_load_value_reg,
  output logic signed [23:0] first_count,
  output logic signed [23:0] second_count
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      first_count <= 24'h000000;
      second_count <= 24'h000000;
    end else begin
      if (first_count_load_reg) begin
        first_count <= first_load_value_reg;
      end else if (set_en) begin
        first_count <= set_first;
      end
      if (second_count_load_reg) begin
        second_count <= second_load_value_reg;
      end else if (set_en) begin
        second_count <= set_second;
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tb_preset_output_reset_control.sv ====
`include "preset_output_consts.vh"
`default_nettype none
module tb_preset_output_reset_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset, psel, penable, pwrite, pready, pslverr, irq, set_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic signed [23:0] first_count, second_count, set_first, set_second;
  logic signed [23:0] first_load_value_reg, second_load_value_reg;
  logic panel_reset_button, first_output_reg, second_output_reg;
  logic first_count_load_reg, second_count_load_reg;
  int n_fail, n_compared, cycles;
  preset_output_reset_control #(.TICK_CYCLES(4)) preset_output_reset_control_inst (.clock,
    .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .first_count, .second_count, .panel_reset_button, .first_output_reg, .second_output_reg,
    .first_count_load_reg, .second_count_load_reg, .first_load_value_reg,
    .second_load_value_reg, .irq);
  count_source_model count_source_model_inst (.clock, .reset, .set_en, .set_first,
    .set_second, .first_count_load_reg, .second_count_load_reg, .first_load_value_reg,
    .second_load_value_reg, .first_count, .second_count);
  // ----------------------------------------
  // Support tasks
  // ----------------------------------------
  task automatic finish_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h00000000, q);
    check(q, e);
  endtask
  task automatic set_counts(input logic [23:0] a, input logic [23:0] b);
    set_en <= 1'b1;
    set_first <= a;
    set_second <= b;
    @(posedge clock);
    set_en <= 1'b0;
    repeat (5) @(posedge clock);
  endtask
  task automatic press();
    panel_reset_button <= 1'b1;
    repeat (4) @(posedge clock);
    panel_reset_button <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_defaults();
    rd(`OFS_OUT1_CFG, 32'h00000002);
    rd(`OFS_OUT2_CFG, 32'h00000002);
    rd(`OFS_SETPT_LO1, 32'h0000000A);
    rd(`OFS_SETPT_HI1, 32'h00000014);
    rd(`OFS_SETPT_LO2, 32'h0000001E);
    rd(`OFS_SETPT_HI2, 32'h00000028);
    rd(`OFS_PRESET1, 32'h00000000);
    rd(`OFS_PRESET2, 32'h00000000);
    rd(`OFS_RESET_CFG, 32'h00000008);
    rd(`OFS_DELAY2, 32'h000003E8);
    rd(12'h0FC, 32'h00000000);
    wr(`OFS_SETPT_HI1, 32'h000F4240);
    rd(`OFS_SETPT_HI1, 32'h000F423F);
    wr(`OFS_SETPT_HI1, 32'hFFFE7960);
    rd(`OFS_SETPT_HI1, 32'hFFFE7961);
  endtask
  task automatic t_latch();
    set_counts(24'h000009, 24'h000000);
    set_counts(24'h00000A, 24'h000000);
    check(32'(first_output_reg), 32'h1);
    check(32'(irq), 32'h0);
    wr(`OFS_IRQ_MASK, 32'h00000001);
    check(32'(irq), 32'h1);
    set_counts(24'h000003, 24'h000000);
    check(32'(first_output_reg), 32'h1);
    wr(`OFS_IRQ_STAT, 32'h00000001);
    check(32'(irq), 32'h0);
  endtask
  task automatic t_button();
    wr(`OFS_PRESET1, 32'hFFFFFFF6);
    wr(`OFS_PRESET2, 32'h00000007);
    press();
    check(32'(first_count), 32'hFFFFFFF6);
    check(32'(second_count), 32'h00000007);
    check(32'(first_output_reg), 32'h0);
    wr(`OFS_RESET_CFG, 32'h00000000);
    set_counts(24'h000005, 24'h000005);
    press();
    check(32'(first_count), 32'h00000005);
  endtask
  task automatic t_boundary();
    wr(`OFS_OUT2_CFG, 32'h00000007);
    set_counts(24'h000000, 24'h000023);
    check(32'(second_output_reg), 32'h1);
    set_counts(24'h000000, 24'h00002D);
    check(32'(second_output_reg), 32'h0);
    set_counts(24'h000023, 24'h000014);
    check(32'(second_output_reg), 32'h0);
    wr(`OFS_OUT2_CFG, 32'h0000000E);
    set_counts(24'h000023, 24'h00001E);
    check(32'(second_count), 32'h00000007);
    check(32'(first_count), 32'h00000023);
  endtask
  task automatic t_timed();
    wr(`OFS_RESET_CFG, 32'h00000008);
    press();
    wr(`OFS_DELAY1, 32'h00000005);
    wr(`OFS_OUT1_CFG, 32'h00000001);
    wr(`OFS_RESET_CFG, 32'h0000000C);
    set_counts(24'h000009, 24'h000007);
    set_counts(24'h00000A, 24'h000007);
    check(32'(first_output_reg), 32'h1);
    repeat (60) @(posedge clock);
    check(32'(first_output_reg), 32'h0);
    check(32'(first_count), 32'hFFFFFFF6);
  endtask
  task automatic t_powerup();
    reset <= 1'b1;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    set_counts(24'h000005, 24'h000005);
    wr(`OFS_RESET_CFG, 32'h00000018);
    repeat (4) @(posedge clock);
    check(32'(first_count), 32'h00000000);
    check(32'(second_count), 32'h00000000);
  endtask
  // ----------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    {psel, penable, pwrite, set_en, panel_reset_button} = '0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    set_first = 24'h000000;
    set_second = 24'h000000;
    {n_fail, n_compared, cycles} = '0;
    reset = 1'b1;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_defaults();
    t_latch();
    t_button();
    t_boundary();
    t_timed();
    t_powerup();
    finish_test();
  end
endmodule
`default_nettype wire
